// File: hw/eif_top.sv
// interrupt enable gating and microframe index counter
`timescale 1ns/10ps
module eif_top #(
  parameter int P_UFRAME_CYC = eif_pkg::UFRAME_CYC
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [3:0]  i_reg_be,
  input  wire logic [31:0] i_reg_wdata,
  input  wire logic        i_run_stop,
  input  wire logic        i_halted,
  input  wire logic [1:0]  i_list_size,
  input  wire logic        i_irq_threshold,
  input  wire logic        i_set_xfer_done,
  input  wire logic        i_set_xfer_err,
  input  wire logic        i_set_port_chg,
  input  wire logic        i_set_host_err,
  input  wire logic        i_set_async_adv,
  input  wire logic [5:0]  i_flag_clr,
  output logic [31:0]      o_reg_rdata,
  output logic             o_reg_rvalid,
  output logic             o_irq,
  output logic [5:0]       o_flags,
  output logic             o_run_stop_clr,
  output logic             o_uframe_end,
  output logic [10:0]      o_sof_frame_num,
  output logic [9:0]       o_list_index
);

  // ****************************************
  // decode helpers
  // ****************************************

  // list size code to top index bit N, reserved code treated as 1024
  function automatic logic [3:0] top_bit(input logic [1:0] list_size_select);
    case (list_size_select)
      eif_pkg::FLS_512: top_bit = 4'hB;
      eif_pkg::FLS_256: top_bit = 4'hA;
      default:          top_bit = 4'hC;
    endcase
  endfunction

  // ****************************************
  // state
  // ****************************************
  logic [5:0]  irq_en_r;
  logic [5:0]  flags_r;
  logic [5:0]  flags_nxt;
  logic [5:0]  armed_r;
  logic [5:0]  armed_nxt;
  logic [13:0] idx_r;
  logic [13:0] idx_nxt;
  logic [13:0] idx_inc;
  logic [13:0] cyc_cnt_r;
  logic        tick;
  logic        wrap_evt;
  logic [3:0]  wrap_pos;
  logic [5:0]  set_vec;
  logic        wr_en;
  logic        wr_idx;
  logic        full_word;

  assign full_word = (i_reg_be == 4'hF);
  assign wr_en     = i_reg_wr && (i_reg_addr == eif_pkg::ADDR_IRQ_EN);
  // index writes honoured only as full words while halted
  assign wr_idx    = i_reg_wr && (i_reg_addr == eif_pkg::ADDR_UF_INDEX)
                     && full_word && i_halted;

  // ****************************************
  // enable register
  // ****************************************

  // reserved bits are not stored and read back as zero
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      irq_en_r <= eif_pkg::IRQ_EN_RESET;
    else if (wr_en && i_reg_be[0])
      irq_en_r <= i_reg_wdata[5:0];
  end

  // ****************************************
  // microframe timebase
  // ****************************************
  assign tick = i_run_stop && !i_halted
                && (cyc_cnt_r == 14'(P_UFRAME_CYC - 1));

  // cycle counter, idle while stopped
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      cyc_cnt_r <= 14'h0000;
    else if (!i_run_stop || i_halted || tick)
      cyc_cnt_r <= 14'h0000;
    else
      cyc_cnt_r <= cyc_cnt_r + 14'h0001;
  end

  // ****************************************
  // frame index
  // ****************************************
  assign idx_inc  = idx_r + 14'h0001;
  assign wrap_pos = top_bit(i_list_size) + 4'h1;
  // rollover seen as a toggle of the bit above the list index
  assign wrap_evt = tick && (idx_r[wrap_pos] != idx_inc[wrap_pos]);

  // next index: software write, else count
  always_comb
  begin
    idx_nxt = idx_r;
    if (wr_idx)
      idx_nxt = i_reg_wdata[13:0];
    else if (tick)
      idx_nxt = idx_inc;
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      idx_r <= eif_pkg::UF_INDEX_RESET;
    else
      idx_r <= idx_nxt;
  end

  // sof number and list index follow the index
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_sof_frame_num <= 11'h000;
      o_list_index    <= 10'h000;
      o_uframe_end    <= 1'b0;
    end
    else
    begin
      o_sof_frame_num <= idx_nxt[13:3];
      o_list_index    <= idx_nxt[12:3]
                         & (10'h3FF >> (4'hC - top_bit(i_list_size)));
      o_uframe_end    <= tick;
    end
  end

  // ****************************************
  // status flags
  // ****************************************
  always_comb
  begin
    set_vec                         = 6'h00;
    set_vec[eif_pkg::BIT_XFER_DONE] = i_set_xfer_done;
    set_vec[eif_pkg::BIT_XFER_ERR]  = i_set_xfer_err;
    set_vec[eif_pkg::BIT_PORT_CHG]  = i_set_port_chg;
    set_vec[eif_pkg::BIT_LIST_WRAP] = wrap_evt;
    set_vec[eif_pkg::BIT_HOST_ERR]  = i_set_host_err;
    set_vec[eif_pkg::BIT_ASYNC_ADV] = i_set_async_adv;
  end

  // flags set regardless of enables, set wins over clear
  assign flags_nxt = (flags_r & ~i_flag_clr) | set_vec;

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      flags_r <= 6'h00;
    else
      flags_r <= flags_nxt;
  end

  // ****************************************
  // threshold pending
  // ****************************************

  // threshold sources arm at a boundary, disarm once acknowledged
  assign armed_nxt = (armed_r | ({6{i_irq_threshold}} & flags_r & irq_en_r
                     & eif_pkg::THRESH_MASK)) & flags_nxt & irq_en_r;

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      armed_r <= 6'h00;
    else
      armed_r <= armed_nxt;
  end

  // ****************************************
  // outputs
  // ****************************************

  // one interrupt: immediate sources plus armed threshold sources
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      o_irq <= 1'b0;
    else
      o_irq <= |((flags_r & irq_en_r & eif_pkg::IMMED_MASK) | armed_r);
  end

  // flag mirror and run/stop clear request
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_flags        <= 6'h00;
      o_run_stop_clr <= 1'b0;
    end
    else
    begin
      o_flags        <= flags_r;
      o_run_stop_clr <= i_set_host_err;
    end
  end

  // read port, one cycle after the request
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_reg_rdata  <= 32'h0000_0000;
      o_reg_rvalid <= 1'b0;
    end
    else
    begin
      o_reg_rvalid <= i_reg_rd;
      if (!i_reg_rd)
        o_reg_rdata <= 32'h0000_0000;
      else if (i_reg_addr == eif_pkg::ADDR_IRQ_EN)
        o_reg_rdata <= {26'h0000000, irq_en_r};
      else if (i_reg_addr == eif_pkg::ADDR_UF_INDEX)
        o_reg_rdata <= {18'h00000, idx_r};
      else
        o_reg_rdata <= 32'h0000_0000;
    end
  end

  // ****************************************
  // checks
  // ****************************************

  a_irq_masked: assert property (@(posedge i_clk) disable iff (i_rst)
    (((flags_r & irq_en_r) == 6'h00) && (armed_r == 6'h00)) |=> !o_irq)
    else $error("interrupt without enabled active source");

  a_imm_irq: assert property (@(posedge i_clk) disable iff (i_rst)
    ((flags_r & irq_en_r & eif_pkg::IMMED_MASK) != 6'h00) |=> o_irq)
    else $error("immediate source did not raise interrupt");

  a_thresh_wait: assert property (@(posedge i_clk) disable iff (i_rst)
    ((armed_r == 6'h00) && ((flags_r & irq_en_r & eif_pkg::IMMED_MASK) == 6'h00)) |=> !o_irq)
    else $error("threshold source fired before boundary");

  a_thresh_arm: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_irq_threshold && flags_r[0] && irq_en_r[0] && !i_flag_clr[0]
     && !(wr_en && i_reg_be[0] && !i_reg_wdata[0])) |=> ##1 o_irq)
    else $error("done source not issued at threshold");

  a_flag_poll: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_set_port_chg && !irq_en_r[eif_pkg::BIT_PORT_CHG]) |=> ##1 o_flags[2])
    else $error("disabled source flag not set");

  a_idx_inc: assert property (@(posedge i_clk) disable iff (i_rst)
    (tick && !wr_idx) |=> (idx_r == $past(idx_r) + 14'h0001))
    else $error("index did not step by one");

  a_tick_space: assert property (@(posedge i_clk) disable iff (i_rst)
    tick |=> !tick && (cyc_cnt_r == 14'h0000))
    else $error("microframe tick spacing wrong");

  a_sof_num: assert property (@(posedge i_clk) disable iff (i_rst)
    o_sof_frame_num == idx_r[13:3])
    else $error("sof number not index bits 13 to 3");

  a_wrap_set: assert property (@(posedge i_clk) disable iff (i_rst)
    (tick && (idx_r[12:0] == 13'h1FFF) && (i_list_size == eif_pkg::FLS_1024))
    |=> flags_r[eif_pkg::BIT_LIST_WRAP])
    else $error("wrap flag not set at rollover");

  a_hse_stop: assert property (@(posedge i_clk) disable iff (i_rst)
    i_set_host_err |=> o_run_stop_clr ##1 o_flags[4])
    else $error("host error did not clear run stop");

  a_idx_write: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_idx |=> (o_sof_frame_num == $past(i_reg_wdata[13:3])))
    else $error("index write did not reach sof number");

  a_wrap_mid: assert property (@(posedge i_clk) disable iff (i_rst)
    (tick && (idx_r[11:0] == 12'hFFF) && (i_list_size == eif_pkg::FLS_512))
    |=> flags_r[eif_pkg::BIT_LIST_WRAP])
    else $error("wrap flag not set at half size rollover");

  a_list_index: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_list_size == eif_pkg::FLS_256) |=> (o_list_index == {2'h0, idx_r[10:3]}))
    else $error("list index not index bits 10 to 3");

  a_rd_enable: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_reg_rd && (i_reg_addr == eif_pkg::ADDR_IRQ_EN))
    |=> o_reg_rvalid && (o_reg_rdata == {26'h0000000, $past(irq_en_r)}))
    else $error("enable read data wrong");

  a_stop_idle: assert property (@(posedge i_clk) disable iff (i_rst)
    (!i_run_stop || i_halted) |=> !o_uframe_end)
    else $error("microframe ended while stopped");

endmodule

// File: hw/eif_pkg.sv
// constants for the interrupt enable and microframe index block
//
// Function
// - host interrupt raised when a source is enabled and its flag is active
// - flags still set for disabled sources so software can poll them
// - enable bit 5 gates async advance flag, issued at next threshold
// - enable bit 4 gates host system error flag, issued immediately
// - enable bit 3 gates frame list wrap flag, issued immediately
// - enable bit 2 gates port change flag, issued immediately
// - enable bit 1 gates transaction error flag, issued at next threshold
// - enable bit 0 gates transfer done flag, issued at next threshold
// - frame index updates once every 125 us microframe while running
// - 14-bit frame index increments by one at each microframe end
// - start-of-frame number is frame index bits 13 to 3
// - list entry index is bits N to 3, each entry used eight microframes
// - list size code 00/01/10 gives N of 12/11/10, code 11 reserved
// - a frame index write also changes later start-of-frame numbers
// - wrap flag set each time the index rolls over for the list size
// - host system error clears run/stop so scheduling stops
package eif_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] ADDR_IRQ_EN   = 8'h28; // interrupt_enable_mask
  localparam logic [7:0] ADDR_UF_INDEX = 8'h2C; // microframe_index
  localparam logic [5:0] IRQ_EN_RESET  = 6'h00;
  localparam logic [13:0] UF_INDEX_RESET = 14'h0000;
  localparam int NUM_SRC = 6;
  localparam int IDX_W   = 14;

  // ****************************************
  // source bit positions
  // ****************************************
  localparam int BIT_XFER_DONE = 0;
  localparam int BIT_XFER_ERR  = 1;
  localparam int BIT_PORT_CHG  = 2;
  localparam int BIT_LIST_WRAP = 3;
  localparam int BIT_HOST_ERR  = 4;
  localparam int BIT_ASYNC_ADV = 5;
  localparam logic [5:0] THRESH_MASK = 6'h23; // bits 5,1,0 wait for threshold
  localparam logic [5:0] IMMED_MASK  = 6'h1C; // bits 4,3,2 immediate

  // ****************************************
  // list size codes and timing
  // ****************************************
  localparam logic [1:0] FLS_1024 = 2'h0;
  localparam logic [1:0] FLS_512  = 2'h1;
  localparam logic [1:0] FLS_256  = 2'h2;
  localparam int UFRAME_NS  = 125000;
  localparam int CLK_NS     = 10;
  localparam int UFRAME_CYC = UFRAME_NS / CLK_NS;

endpackage

// File: tb/eif_host_model.sv
// host software model driving the register strobes
`timescale 1ns/10ps
module eif_host_model (
  input  wire logic        i_clk,
  input  wire logic        i_rvalid,
  input  wire logic [31:0] i_rdata,
  output logic             o_wr,
  output logic             o_rd,
  output logic [7:0]       o_addr,
  output logic [3:0]       o_be,
  output logic [31:0]      o_wdata
);
  // idle bus values at time zero
  initial
  begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 8'h00;
    o_be = 4'h0;
    o_wdata = 32'h0000_0000;
  end
  // one word write, data inverted once released
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_clk) #1;
    o_addr = a;
    o_be = 4'hF;
    o_wdata = v & ((a == 8'h2C) ? 32'h0000_3FFF : 32'h0000_003F);
    o_wr = 1'b1;
    @(posedge i_clk) #1;
    o_wr = 1'b0;
    o_wdata = ~o_wdata;
  endtask
  // one word read, bounded wait for valid
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic ok);
    ok = 1'b0;
    v = 32'h0000_0000;
    @(posedge i_clk) #1;
    o_addr = a;
    o_rd = 1'b1;
    @(posedge i_clk) #1;
    o_rd = 1'b0;
    for (int i = 0; i < 4 && !ok; i++)
    begin
      if (i_rvalid === 1'b1)
      begin
        v = i_rdata;
        ok = 1'b1;
      end
      else
        @(posedge i_clk) #1;
    end
  endtask
endmodule

// File: tb/ehci_irq_enable_frame_index_tb.sv
// self-checking bench for the interrupt enable and microframe index block
`timescale 1ns/10ps
module ehci_irq_enable_frame_index_tb;
  logic        clk, rst, wr, rd, run, hlt, thr, rv, irq, rsc, ufe, rsc_s;
  logic [7:0]  addr;
  logic [3:0]  be;
  logic [31:0] wd, rdat, d;
  logic [1:0]  ls;
  logic [5:0]  ev, clr, flg, en;
  logic [10:0] sof;
  logic [9:0]  li;
  logic [13:0] w;
  int          err_total, n_tests, b, nb, cnt;
  int          src[5] = '{0, 1, 2, 4, 5};
  always #5 clk = ~clk;
  eif_top #(.P_UFRAME_CYC(8)) dut_u (.i_clk(clk), .i_rst(rst), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
    .i_reg_be(be), .i_reg_wdata(wd), .i_run_stop(run), .i_halted(hlt), .i_list_size(ls), .i_irq_threshold(thr),
    .i_set_xfer_done(ev[0]), .i_set_xfer_err(ev[1]), .i_set_port_chg(ev[2]), .i_set_host_err(ev[4]),
    .i_set_async_adv(ev[5]), .i_flag_clr(clr), .o_reg_rdata(rdat), .o_reg_rvalid(rv), .o_irq(irq), .o_flags(flg),
    .o_run_stop_clr(rsc), .o_uframe_end(ufe), .o_sof_frame_num(sof), .o_list_index(li));
  eif_host_model host_u (.i_clk(clk), .i_rvalid(rv), .i_rdata(rdat), .o_wr(wr), .o_rd(rd), .o_addr(addr),
    .o_be(be), .o_wdata(wd));
  // compare and count
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_tests++;
    if (g !== e)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string m);
    logic ok;
    host_u.rd(a, d, ok);
    if (!ok)
    begin
      chk(32'h0, 32'h1, "read timeout");
      report_and_stop();
    end
    else
      chk(d, e, m);
  endtask
  // one cycle of event, clear and threshold pulses, then let outputs settle
  task automatic strobe(input logic [5:0] e, input logic [5:0] c, input logic t);
    @(posedge clk) #1;
    ev = e;
    clr = c;
    thr = t;
    @(posedge clk) #1;
    ev = 6'h00;
    clr = 6'h00;
    thr = 1'b0;
    rsc_s = rsc;
    repeat (2) @(posedge clk);
    #1;
  endtask
  // expected list entry index for a size code
  function automatic logic [9:0] exp_li(input logic [13:0] x, input logic [1:0] s);
    case (s)
      2'h1: return {1'b0, x[11:3]};
      2'h2: return {2'h0, x[10:3]};
      default: return x[12:3];
    endcase
  endfunction
  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    run = 1'b0;
    hlt = 1'b1;
    thr = 1'b0;
    ls = 2'h0;
    ev = 6'h00;
    clr = 6'h00;
    err_total = 0;
    n_tests = 0;
    void'($urandom(32'h6809f88f));
    repeat (6) @(posedge clk);
    #1;
    rst = 1'b0;
    rdchk(8'h28, 32'h0, "enable reset");
    rdchk(8'h2C, 32'h0, "index reset");
    rdchk(8'h40, 32'h0, "unmapped read");
    // each source except list wrap enabled, then masked
    foreach (src[k])
    begin
      b = src[k];
      en = 6'($urandom) | 6'(1 << b);
      host_u.wr(8'h28, {26'h0, en});
      rdchk(8'h28, {26'h0, en}, "enable readback");
      strobe(6'(1 << b), 6'h00, 1'b0);
      chk(irq, (b == 2 || b == 4), "irq before threshold");
      chk(flg[b], 1'b1, "flag set");
      chk(rsc_s, (b == 4), "run stop clear");
      strobe(6'h00, 6'h00, 1'b1);
      chk(irq, 1'b1, "irq after threshold");
      strobe(6'h00, 6'(1 << b), 1'b0);
      chk({irq, flg}, 7'h00, "acknowledge");
      host_u.wr(8'h28, {26'h0, en & ~6'(1 << b)});
      strobe(6'(1 << b), 6'h00, 1'b1);
      chk({irq, flg}, {1'b0, 6'(1 << b)}, "masked source polled");
      strobe(6'h00, 6'h3F, 1'b0);
    end
    // index counting across a wrap for every size code
    for (int s = 0; s < 4; s++)
    begin
      nb = (s == 1) ? 11 : (s == 2) ? 10 : 12;
      ls = 2'(s);
      w = 14'($urandom) | 14'((1 << (nb + 1)) - 2);
      host_u.wr(8'h2C, {18'h0, w});
      rdchk(8'h2C, {18'h0, w}, "index write");
      chk(sof, w[13:3], "sof after write");
      @(posedge clk) #1;
      cnt = 0;
      for (int c = 0; c < 31; c++)
      begin
        run = (c < 27);
        hlt = (c >= 27);
        @(posedge clk) #1;
        cnt += (ufe === 1'b1);
      end
      w = w + 14'h3;
      chk(cnt, 3, "microframe ticks");
      chk(flg[3], 1'b1, "wrap flag");
      chk(sof, w[13:3], "sof number");
      chk(li, exp_li(w, ls), "list index");
      rdchk(8'h2C, {18'h0, w}, "index count");
      strobe(6'h00, 6'h3F, 1'b0);
      chk(flg[3], 1'b0, "wrap cleared");
    end
    // mid-run reset returns both registers and the index outputs to zero
    @(posedge clk) #1;
    rst = 1'b1;
    @(posedge clk) #1;
    rst = 1'b0;
    chk({sof, li}, 21'h0, "outputs after reset");
    rdchk(8'h28, 32'h0, "enable after reset");
    rdchk(8'h2C, 32'h0, "index after reset");
    report_and_stop();
  end
endmodule
